// ---- core/aacc_top.sv ----
// Accumulating and averaging back end of a successive-approximation converter.
// Assumes an AXI4-Lite master and converter data valid when a conversion ends.
//
// Overview of operation
// - Start only after synchronised software or event request, or on completion when free running.
// - Sample input in first conversion half period.
// - Sampling length field lengthens the sampling phase.
// - Code k up to ten accumulates two to k samples; higher codes take one.
// - Sample count taken from code, sum grows.
// - Sums above sixteen samples must not overflow.
// - Codes five to ten shift by code minus four.
// - Codes up to four apply no automatic shift.
// - Averaging divides the accumulated sum by m.
// - Adjust shift adds to automatic shift, twelve bits.
// - One result per completed accumulation set.
// - Result ready flag only after final value.
// - Each result replaces the previous result register.
// - Free running restarts when previous conversion completes.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`include "aacc_defines.svh"
`default_nettype none
module aacc_top #(
	parameter int DATA_W   = 12,
	parameter int ACC_W    = 22,
	parameter int CNT_W    = 11,
	parameter int LEN_W    = 6,
	parameter int HALF_DIV = 2
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [`AACC_AW-1:0] awaddr,
	input  wire logic               awvalid,
	output logic                    awready,
	input  wire logic [31:0]        wdata,
	input  wire logic [3:0]         wstrb,
	input  wire logic               wvalid,
	output logic                    wready,
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  wire logic               bready,
	input  wire logic [`AACC_AW-1:0] araddr,
	input  wire logic               arvalid,
	output logic                    arready,
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  wire logic               rready,
	input  wire logic               evt_start,
	input  wire logic [DATA_W-1:0]  sar_data,
	output logic                    sample_hold,
	output logic                    irq
);
	// Sample-count decode: number of samples in one set.
	function automatic logic [CNT_W-1:0] aacc_target(input logic [3:0] code);
		aacc_target = (code <= `AACC_CODE_MAX) ? (CNT_W'(1) << code) : CNT_W'(1);
	endfunction : aacc_target

	// Automatic right shift that keeps a large sum inside sixteen bits.
	function automatic logic [3:0] aacc_auto(input logic [3:0] code);
		aacc_auto = (code > `AACC_AUTO_BASE && code <= `AACC_CODE_MAX) ?
			code - `AACC_AUTO_BASE : 4'h0;
	endfunction : aacc_auto

	////////////////////////////////////////////////////////////////////////
	// Bus-side state.
	logic               aw_have_q, w_have_q;
	logic [`AACC_AW-1:0] aw_addr_q;
	logic [31:0]        w_data_q;
	logic [3:0]         w_strb_q;
	// Software-visible registers.
	logic               enable_q, free_run_q, evt_en_q;
	logic [1:0]         resolution_select_q;
	logic [LEN_W-1:0]   sampling_length_q;
	logic [3:0]         sample_count_code_q;
	logic [2:0]         adjust_shift_q;
	logic [1:0]         interrupt_flag_q, interrupt_mask_q;
	logic [15:0]        result_q;
	// Sequencing and accumulation.
	logic               start_pend_q, conv_start_q;
	logic [ACC_W-1:0]   acc_q;
	logic [CNT_W-1:0]   sample_cnt_q;
	logic               conv_busy, conv_done;
	logic [DATA_W-1:0]  conv_data;

	////////////////////////////////////////////////////////////////////////
	// Write channel decode; a write fires once address and data are both held.
	wire aw_take = awvalid && awready;
	wire w_take  = wvalid && wready;
	wire wr_fire = aw_have_q && w_have_q && !bvalid;
	wire lane0   = w_strb_q[0];
	wire we_ctrl = wr_fire && lane0 && (aw_addr_q == `AACC_A_CTRL);
	wire we_trig = wr_fire && lane0 && (aw_addr_q == `AACC_A_SWTRIG);
	wire we_samp = wr_fire && lane0 && (aw_addr_q == `AACC_A_SAMPLING_TIME_CONTROL);
	wire we_avg  = wr_fire && lane0 && (aw_addr_q == `AACC_A_AVERAGING_CONTROL);
	wire we_flag = wr_fire && lane0 && (aw_addr_q == `AACC_A_FLAG);
	wire we_mask = wr_fire && lane0 && (aw_addr_q == `AACC_A_MASK);
	wire wr_hit  = (aw_addr_q == `AACC_A_CTRL) || (aw_addr_q == `AACC_A_SWTRIG) ||
		(aw_addr_q == `AACC_A_SAMPLING_TIME_CONTROL) || (aw_addr_q == `AACC_A_AVERAGING_CONTROL) ||
		(aw_addr_q == `AACC_A_FLAG) || (aw_addr_q == `AACC_A_MASK) ||
		(aw_addr_q == `AACC_A_RESULT) || (aw_addr_q == `AACC_A_STATUS);
	wire aw_have_d = (aw_have_q || aw_take) && !wr_fire;
	wire w_have_d  = (w_have_q || w_take) && !wr_fire;
	wire bvalid_d  = wr_fire || (bvalid && !bready);

	// Address and data are taken in either order and held until the write.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= `AACC_RESP_OKAY;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awready   <= !aw_have_d;
			wready    <= !w_have_d;
			bvalid    <= bvalid_d;
			if (wr_fire)
				bresp <= wr_hit ? `AACC_RESP_OKAY : `AACC_RESP_SLVERR;
		end
	end

	// Payload capture; no reset needed since the have flags guard it.
	always_ff @(posedge aclk)
	begin
		if (aw_take)
			aw_addr_q <= awaddr;
		if (w_take)
		begin
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control fields; writes to the result or status word are ignored.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			enable_q            <= 1'b0;
			free_run_q          <= 1'b0;
			evt_en_q            <= 1'b0;
			resolution_select_q <= `AACC_RESOLUTION_SELECT_RST;
			sampling_length_q   <= '0;
			sample_count_code_q <= `AACC_CODE_RST;
			adjust_shift_q      <= `AACC_ADJ_RST;
			interrupt_mask_q    <= 2'h0;
		end
		else
		begin
			if (we_ctrl)
			begin
				enable_q            <= w_data_q[`AACC_CTRL_EN];
				free_run_q          <= w_data_q[`AACC_CTRL_FREE];
				evt_en_q            <= w_data_q[`AACC_CTRL_EVT];
				resolution_select_q <= w_data_q[`AACC_CTRL_RES_HI:`AACC_CTRL_RES_LO];
			end
			if (we_samp)
				sampling_length_q <= w_data_q[LEN_W-1:0];
			if (we_avg)
			begin
				sample_count_code_q <= w_data_q[`AACC_AVG_CODE_HI:`AACC_AVG_CODE_LO];
				adjust_shift_q      <= w_data_q[`AACC_AVG_ADJ_HI:`AACC_AVG_ADJ_LO];
			end
			if (we_mask)
				interrupt_mask_q <= w_data_q[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start requests are held pending and issued from a register stage,
	// which is the point where they are aligned to the converter clock.
	wire sw_start = we_trig && w_data_q[`AACC_TRIG_START];
	wire evt_go   = evt_start && evt_en_q;
	wire free_go  = conv_done && free_run_q;
	wire start_rq = enable_q && (sw_start || evt_go || free_go);
	wire issue    = start_pend_q && enable_q && !conv_busy && !conv_start_q;
	wire pend_d   = start_rq || (start_pend_q && !issue && enable_q);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			start_pend_q <= 1'b0;
			conv_start_q <= 1'b0;
		end
		else
		begin
			start_pend_q <= pend_d;
			conv_start_q <= issue;
		end
	end

	// Sequencer for one conversion.
	aacc_conv_engine #(
		.HALF_DIV (HALF_DIV),
		.LEN_W    (LEN_W),
		.DATA_W   (DATA_W)
	) u_conv (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.start       (conv_start_q),
		.samp_len    (sampling_length_q),
		.sar_data    (sar_data),
		.sample_hold (sample_hold),
		.busy        (conv_busy),
		.done        (conv_done),
		.data        (conv_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Accumulation: the first sample of a set starts from zero, so a stale
	// partial sum never leaks into the next result.
	wire [CNT_W-1:0] target   = aacc_target(sample_count_code_q);
	wire             last     = (sample_cnt_q == target - CNT_W'(1));
	wire [ACC_W-1:0] acc_base = (sample_cnt_q == '0) ? '0 : acc_q;
	wire [ACC_W-1:0] sum_d    = acc_base + ACC_W'(conv_data);
	wire [3:0]       auto_sh  = aacc_auto(sample_count_code_q);
	wire [ACC_W-1:0] shifted  = (sum_d >> auto_sh) >> adjust_shift_q;
	wire             rdy_set  = conv_done && last;
	wire             set_clr  = we_avg || !enable_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || set_clr)
		begin
			acc_q        <= '0;
			sample_cnt_q <= '0;
		end
		else if (rdy_set)
		begin
			acc_q        <= '0;
			sample_cnt_q <= '0;
		end
		else if (conv_done)
		begin
			acc_q        <= sum_d;
			sample_cnt_q <= sample_cnt_q + CNT_W'(1);
		end
	end

	// Result word is replaced only when a whole set completes.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			result_q <= 16'h0000;
		else if (rdy_set)
			result_q <= shifted[15:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flags; a new event wins over a write-one clear in the same cycle.
	// Overrun marks a result that replaced one software never acknowledged.
	wire [1:0] flag_clr = we_flag ? w_data_q[1:0] : 2'h0;
	wire [1:0] flag_set = {rdy_set && interrupt_flag_q[`AACC_FLAG_RDY], rdy_set};
	wire [1:0] flag_d   = flag_set | (interrupt_flag_q & ~flag_clr);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			interrupt_flag_q <= 2'h0;
			irq              <= 1'b0;
		end
		else
		begin
			interrupt_flag_q <= flag_d;
			irq              <= |(flag_d & interrupt_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path; unmapped addresses answer zero with an error response.
	wire ar_take  = arvalid && arready;
	wire rvalid_d = ar_take || (rvalid && !rready);
	wire [31:0] ctrl_word = {26'h0, resolution_select_q, 1'b0, evt_en_q, free_run_q, enable_q};
	wire [31:0] avg_word  = {25'h0, adjust_shift_q, sample_count_code_q};
	wire [31:0] stat_word = {5'h0, sample_cnt_q, 14'h0, start_pend_q, conv_busy};
	wire rd_hit = (araddr == `AACC_A_CTRL) || (araddr == `AACC_A_SWTRIG) ||
		(araddr == `AACC_A_SAMPLING_TIME_CONTROL) || (araddr == `AACC_A_AVERAGING_CONTROL) ||
		(araddr == `AACC_A_FLAG) || (araddr == `AACC_A_MASK) ||
		(araddr == `AACC_A_RESULT) || (araddr == `AACC_A_STATUS);
	wire [31:0] rd_word =
		(araddr == `AACC_A_CTRL)     ? ctrl_word :
		(araddr == `AACC_A_SAMPLING_TIME_CONTROL) ? 32'(sampling_length_q) :
		(araddr == `AACC_A_AVERAGING_CONTROL)  ? avg_word :
		(araddr == `AACC_A_FLAG)     ? {30'h0, interrupt_flag_q} :
		(araddr == `AACC_A_MASK)     ? {30'h0, interrupt_mask_q} :
		(araddr == `AACC_A_RESULT)   ? {16'h0, result_q} :
		(araddr == `AACC_A_STATUS)   ? stat_word : 32'h0000_0000;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `AACC_RESP_OKAY;
		end
		else
		begin
			arready <= !rvalid_d;
			rvalid  <= rvalid_d;
			if (ar_take)
			begin
				rdata <= rd_word;
				rresp <= rd_hit ? `AACC_RESP_OKAY : `AACC_RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	start_sync_a: assert property (conv_start_q |-> $past(start_pend_q) && $past(enable_q))
		else $error("conversion started without a pending request");
	free_restart_a: assert property ((conv_done && free_run_q && enable_q && !we_ctrl)
		|-> ##[1:3] conv_start_q)
		else $error("free running did not restart");
	set_clear_a: assert property (rdy_set && !set_clr |=> sample_cnt_q == '0 && acc_q == '0)
		else $error("accumulator not cleared after a set");
	no_shift_a: assert property ((rdy_set && sample_count_code_q <= `AACC_AUTO_BASE &&
		adjust_shift_q == 3'h0) |=> result_q == $past(sum_d[15:0]))
		else $error("small set was shifted");
	auto_shift_a: assert property ((rdy_set && sample_count_code_q > `AACC_AUTO_BASE &&
		sample_count_code_q <= `AACC_CODE_MAX && adjust_shift_q == 3'h0)
		|=> result_q == 16'($past(sum_d) >> ($past(sample_count_code_q) - 4'h4)))
		else $error("automatic shift wrong");
	avg_width_a: assert property ((rdy_set && sample_count_code_q <= `AACC_CODE_MAX &&
		32'(adjust_shift_q) == ((sample_count_code_q < 4'h4) ? 32'(sample_count_code_q) : 4))
		|=> result_q[15:12] == 4'h0)
		else $error("averaged result wider than twelve bits");
	ready_final_a: assert property ($rose(interrupt_flag_q[`AACC_FLAG_RDY])
		|-> $past(conv_done) && $past(last))
		else $error("ready flag set before the set completed");
	result_hold_a: assert property (!$stable(result_q) |-> $past(rdy_set))
		else $error("result changed without a completed set");
	flag_set_wins_a: assert property ((rdy_set && we_flag && w_data_q[0])
		|=> interrupt_flag_q[`AACC_FLAG_RDY])
		else $error("ready event lost to a clear");

	full_set_c: cover property (rdy_set && sample_count_code_q == `AACC_CODE_MAX);
	free_run_c: cover property (conv_done && free_run_q ##[1:3] conv_start_q);
	overrun_c: cover property (flag_set[`AACC_FLAG_OVR]);
endmodule : aacc_top
`default_nettype wire

// ---- core/aacc_defines.svh ----
// Offsets, field positions, reset values and timing counts of the accumulator.
// Assumes inclusion by bare name from every file that needs them.
`ifndef AACC_DEFINES_SVH
`define AACC_DEFINES_SVH
`define AACC_AW          8
`define AACC_A_CTRL      8'h00
`define AACC_A_SWTRIG    8'h04
`define AACC_A_SAMPLING_TIME_CONTROL  8'h08
`define AACC_A_AVERAGING_CONTROL   8'h0C
`define AACC_A_FLAG      8'h10
`define AACC_A_MASK      8'h14
`define AACC_A_RESULT    8'h18
`define AACC_A_STATUS    8'h1C
`define AACC_CTRL_EN     0
`define AACC_CTRL_FREE   1
`define AACC_CTRL_EVT    2
`define AACC_CTRL_RES_LO 4
`define AACC_CTRL_RES_HI 5
`define AACC_TRIG_START  0
`define AACC_AVG_CODE_LO 0
`define AACC_AVG_CODE_HI 3
`define AACC_AVG_ADJ_LO  4
`define AACC_AVG_ADJ_HI  6
`define AACC_FLAG_RDY    0
`define AACC_FLAG_OVR    1
`define AACC_STAT_BUSY   0
`define AACC_STAT_PEND   1
`define AACC_STAT_CNT_LO 16
`define AACC_RESOLUTION_SELECT_RST  2'h0
`define AACC_CODE_RST    4'h0
`define AACC_ADJ_RST     3'h0
`define AACC_CODE_MAX    4'hA
`define AACC_AUTO_BASE   4'h4
`define AACC_CONV_LAST   8'h0B
`define AACC_RESP_OKAY   2'h0
`define AACC_RESP_SLVERR 2'h2
`endif

// ---- core/aacc_pkg.sv ----
// Types of the accumulator's conversion sequencer; the top module does not use them.
// Assumes nothing of its surroundings.
`default_nettype none
package aacc_pkg;
	typedef enum logic [1:0] {
		AACC_IDLE    = 2'b00,
		AACC_SAMPLE  = 2'b01,
		AACC_CONVERT = 2'b10
	} aacc_conv_state_t;
endpackage : aacc_pkg
`default_nettype wire

// ---- core/aacc_conv_engine.sv ----
// Conversion sequencer: sampling window, conversion phase and result capture.
// Assumes a synchronous start pulse and converter data valid at the end.
`include "aacc_defines.svh"
`default_nettype none
module aacc_conv_engine #(
	parameter int HALF_DIV = 2,
	parameter int LEN_W    = 6,
	parameter int DATA_W   = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              start,
	input  wire logic [LEN_W-1:0]  samp_len,
	input  wire logic [DATA_W-1:0] sar_data,
	output logic                   sample_hold,
	output logic                   busy,
	output logic                   done,
	output logic [DATA_W-1:0]      data
);
	localparam int CW = LEN_W + 2;
	localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);
	aacc_pkg::aacc_conv_state_t state_q, state_d;
	logic [7:0]    div_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	wire           half_en  = (div_q == DIV_LAST);
	wire           cnt_zero = (cnt_q == '0);
	wire           go       = start && (state_q == aacc_pkg::AACC_IDLE);
	wire           fin      = (state_q == aacc_pkg::AACC_CONVERT) && half_en && cnt_zero;

	////////////////////////////////////////////////////////////////////////
	// Next state; the window lasts one half period plus samp_len halves.
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			aacc_pkg::AACC_IDLE:
			begin
				if (go)
				begin
					state_d = aacc_pkg::AACC_SAMPLE;
					cnt_d   = CW'(samp_len);
				end
			end
			aacc_pkg::AACC_SAMPLE:
			begin
				if (half_en && cnt_zero)
				begin
					state_d = aacc_pkg::AACC_CONVERT;
					cnt_d   = CW'(`AACC_CONV_LAST);
				end
				else if (half_en)
					cnt_d = cnt_q - CW'(1);
			end
			aacc_pkg::AACC_CONVERT:
			begin
				if (fin)
					state_d = aacc_pkg::AACC_IDLE;
				else if (half_en)
					cnt_d = cnt_q - CW'(1);
			end
			default:
				state_d = aacc_pkg::AACC_IDLE;
		endcase
	end

	// Divider restarts on start so the first half period is whole.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || go || half_en)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// State and registered outputs.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q     <= aacc_pkg::AACC_IDLE;
			cnt_q       <= '0;
			sample_hold <= 1'b0;
			busy        <= 1'b0;
			done        <= 1'b0;
			data        <= '0;
		end
		else
		begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			sample_hold <= (state_d == aacc_pkg::AACC_SAMPLE);
			busy        <= (state_d != aacc_pkg::AACC_IDLE);
			done        <= fin;
			if (fin)
				data <= sar_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sample_first_a: assert property (go |=> sample_hold)
		else $error("sampling did not open after start");
	sample_len_a: assert property (
		(state_q == aacc_pkg::AACC_SAMPLE && half_en && !cnt_zero) |=> sample_hold)
		else $error("sampling window closed early");
	done_pulse_a: assert property (done |=> !done)
		else $error("done lasted more than one cycle");
endmodule : aacc_conv_engine
`default_nettype wire

// ---- test/aacc_top_tb.sv ----
// Self-checking bench for the accumulating converter back end, driven over AXI4-Lite.
// Assumes the core/ design files and the shared defines header on the include path.
`include "aacc_defines.svh"
`default_nettype none

// Compares a value against its expectation and counts the outcome.
`define CHECK(g, e) \
	begin \
		n_tests++; \
		if ((g) !== (e)) \
		begin \
			miscompares++; \
			$display("wrong value at %0t: got %0h, expected %0h", $time, (g), (e)); \
		end \
	end

module aacc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// One aclk cycle per half period keeps 1024-sample sets short.
	localparam int HALF = 1;
	localparam logic [31:0] CTL_ONE  = 32'h11;
	localparam logic [31:0] CTL_FREE = 32'h13;
	localparam logic [31:0] CTL_EVT  = 32'h15;

	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        evt_start;
	logic [11:0] sar_data;
	logic        sample_hold;
	logic        irq;
	logic [1:0]  last_resp;
	logic [31:0] rd;
	logic        sh_prev;
	logic        irq_prev;
	int          miscompares;
	int          n_tests;
	int          rises;
	int          snap;
	int          hold_cnt;
	int          hold_len;

	aacc_top #(.HALF_DIV(HALF)) i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.evt_start(evt_start), .sar_data(sar_data),
		.sample_hold(sample_hold), .irq(irq)
	);

	// Free-running 20 MHz clock.
	always #25 aclk = ~aclk;

	// Counts sampling windows and their widths, and snapshots the count when a result is flagged.
	always @(posedge aclk)
	begin
		sh_prev <= sample_hold;
		irq_prev <= irq;
		if (sample_hold && !sh_prev) rises <= rises + 1;
		hold_cnt <= sample_hold ? hold_cnt + 1 : 0;
		if (!sample_hold && sh_prev) hold_len <= hold_cnt;
		if (irq && !irq_prev) snap <= rises;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus tasks. Each lets one edge pass at the end so no signal is driven twice at once.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				last_resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		@(posedge aclk);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				d = rdata;
				last_resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		@(posedge aclk);
	endtask : axi_read

	// Bounded wait for the result interrupt; the watchdog covers anything longer.
	task automatic wait_irq();
		for (int i = 0; i < 40000; i++)
		begin
			@(posedge aclk);
			if (irq === 1'b1) break;
		end
		`CHECK(irq, 1'b1)
	endtask : wait_irq

	// Expected result: sum of 2^code equal samples (one for codes above ten), automatic shift, then adjust shift.
	function automatic logic [15:0] expect_result(input logic [3:0] code, input logic [2:0] adj,
		input logic [11:0] s);
		logic [31:0] sum;
		int          auto_sh;
		sum = (code <= 4'hA) ? ({20'h0, s} << code) : {20'h0, s};
		auto_sh = (code > 4'h4 && code <= 4'hA) ? code - 4 : 0;
		sum = (sum >> auto_sh) >> adj;
		return sum[15:0];
	endfunction : expect_result

	// Runs one accumulation set from a clean start and checks value and sample count.
	task automatic run_set(input logic [3:0] code, input logic [2:0] adj, input logic [31:0] ctl,
		input logic [11:0] s);
		int base;
		int n;
		n = (code <= 4'hA) ? (1 << code) : 1;
		sar_data <= s;
		axi_write(`AACC_A_CTRL, 32'h0);
		// A free-running conversion still in flight would finish after the flag clear
		// below and fake an early result, so wait for the engine to go idle first.
		for (int i = 0; i < 200; i++)
		begin
			axi_read(`AACC_A_STATUS, rd);
			if (rd[`AACC_STAT_BUSY] === 1'b0) break;
		end
		axi_write(`AACC_A_AVERAGING_CONTROL, {25'h0, adj, code});
		axi_write(`AACC_A_FLAG, 32'h3);
		base = rises;
		axi_write(`AACC_A_CTRL, ctl);
		if (ctl[`AACC_CTRL_EVT])
		begin
			evt_start <= 1'b1;
			@(posedge aclk);
			evt_start <= 1'b0;
		end
		else
			axi_write(`AACC_A_SWTRIG, 32'h1);
		wait_irq();
		axi_read(`AACC_A_RESULT, rd);
		axi_write(`AACC_A_CTRL, 32'h0);
		`CHECK(rd[15:0], expect_result(code, adj, s))
		`CHECK(snap - base, n)
	endtask : run_set

	task automatic print_verdict();
		$display("Comparisons: %0d, mismatches: %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		int base;
		int lens [3];
		lens = '{0, 5, 63};
		aclk = 1'b0;
		aresetn = 1'b0;
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready, evt_start} = '0;
		wstrb = 4'hF;
		sar_data = 12'h000;
		{sh_prev, irq_prev} = 2'b00;
		{miscompares, n_tests, rises, snap, hold_cnt, hold_len} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		`CHECK(irq, 1'b0)
		`CHECK(sample_hold, 1'b0)
		// Unmapped places answer with an error.
		axi_read(8'h20, rd);
		`CHECK(last_resp, `AACC_RESP_SLVERR)
		axi_write(8'h24, 32'h1);
		`CHECK(last_resp, `AACC_RESP_SLVERR)
		// A start while disabled must not launch a conversion.
		base = rises;
		axi_write(`AACC_A_SWTRIG, 32'h1);
		repeat (40) @(posedge aclk);
		`CHECK(rises, base)
		axi_write(`AACC_A_MASK, 32'h1);
		// Sampling window grows with the programmed length.
		foreach (lens[i])
		begin
			axi_write(`AACC_A_SAMPLING_TIME_CONTROL, lens[i]);
			run_set(4'h0, 3'h0, CTL_ONE, 12'h5A3);
			`CHECK(hold_len, (lens[i] + 1) * HALF)
		end
		axi_write(`AACC_A_SAMPLING_TIME_CONTROL, 32'h0);
		// Every accumulation code, full-scale input, plus one reserved code.
		for (int k = 0; k <= 11; k++)
			run_set(k[3:0], 3'h0, CTL_FREE, 12'hFFF);
		// Averaging with the adjust shift that restores a 12-bit value.
		foreach (lens[i])
			run_set(4'h1 + 4'(i * 3), 3'h4 - 3'(i == 0) * 3'h3, CTL_FREE, 12'hA5B);
		`CHECK(rd[15:0], 16'h0A5B)
		// Event-driven start.
		run_set(4'h0, 3'h0, CTL_EVT, 12'h123);
		// Masked flag holds the interrupt low until unmasked, then write-one clears it.
		axi_write(`AACC_A_MASK, 32'h0);
		axi_write(`AACC_A_FLAG, 32'h3); // The event run left its flag set.
		axi_write(`AACC_A_CTRL, CTL_ONE);
		axi_write(`AACC_A_SWTRIG, 32'h1);
		for (int i = 0; i < 100; i++)
		begin
			axi_read(`AACC_A_FLAG, rd);
			if (rd[`AACC_FLAG_RDY] === 1'b1) break;
		end
		`CHECK(rd[`AACC_FLAG_RDY], 1'b1)
		`CHECK(irq, 1'b0)
		axi_write(`AACC_A_MASK, 32'h1);
		`CHECK(irq, 1'b1)
		axi_write(`AACC_A_FLAG, 32'h1);
		`CHECK(irq, 1'b0)
		axi_read(`AACC_A_FLAG, rd);
		`CHECK(rd[`AACC_FLAG_RDY], 1'b0)
		print_verdict();
	end

	// Watchdog sized well above the roughly 37000 cycles the sequence needs.
	initial
	begin
		repeat (90000) @(posedge aclk);
		miscompares++;
		$display("wrong value at %0t: run did not finish", $time);
		print_verdict();
	end
endmodule : aacc_top_tb
`default_nettype wire
